//--- common/pdh_pkg.sv
// Purpose: Shared constants for the palette DAC host port
// Assumes: Core clock at 50 MHz; host strobe is asynchronous to it
// Notes:   Command codes other than the cursor and pointer codes are left to the core behind the port
package pdh_pkg;
    localparam int          DATA_W       = 8;
    localparam int          CMD_W        = 2;
    localparam int          CUR_ADDR_W   = 10;
    localparam int          CUR_DEPTH    = 1024;
    localparam logic [7:0]  DATA_RST     = 8'h00;
    localparam logic [1:0]  CMD_RST      = 2'h0;
    // Command code that steers an access to the cursor pattern memory
    localparam logic [1:0]  CMD_CURSOR   = 2'h3;
    // Command code that steers a write to the address pointer; a read returns core read data
    localparam logic [1:0]  CMD_POINTER  = 2'h0;
    localparam logic [9:0]  PTR_RST      = 10'h000;
    localparam int          SYNC_STAGES  = 3;
endpackage

//--- core/pdh_cursor_mem.sv
// Purpose: Cursor pattern memory, one write and one registered read port
// Assumes: Single clock, no reset on the array
// Notes:   Read data come from a register, one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module pdh_cursor_mem
    import pdh_pkg::*;
#(
    parameter int AW = CUR_ADDR_W,
    parameter int DW = DATA_W
) (
    input  wire logic          clock,    // Core clock
    input  wire logic          wr_en,    // Write strobe
    input  wire logic [AW-1:0] wr_addr,  // Write address
    input  wire logic [DW-1:0] wr_data,  // Write data
    input  wire logic [AW-1:0] rd_addr,  // Read address
    output logic      [DW-1:0] rd_data   // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

//--- core/pdh_host_port.sv
// Purpose: Asynchronous eight-bit host port of a palette DAC, timed by its strobe
// Assumes: Strobe, direction, command and data pins arrive asynchronous to clock
// Notes:   Strobe edges are detected after a three-stage synchroniser
//
// Contract
// - A transfer happens only while the active-low chip select is low.
// - Write data are captured when the chip select rises at the end of a write.
// - Chip select low with read/write select low makes a write.
// - Chip select low with read/write select high makes a read that returns data.
// - The read/write select is caught at the falling strobe edge and held for the access.
// - The command select is caught at the falling strobe edge and picks the operation.
// - Data travel over one eight-bit bus with bit 0 as least significant.
// - The core runs on its own pixel-rate clock, apart from the strobe-timed port; here the port also runs on the core clock and samples the strobe.
// - Cursor memory accesses from the host are addressed by the internal address pointer.
// - Host cursor accesses win over the display fetch, so hosts avoid them during sync.
`timescale 1ns/1ns
`default_nettype none
module pdh_host_port
    import pdh_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = CUR_ADDR_W
) (
    input  wire logic          clock,          // Core pixel-rate clock
    input  wire logic          rst,            // Asynchronous reset, active high
    input  wire logic          chip_sel_n,     // Host strobe, active low
    input  wire logic          read_sel,       // High for read, low for write
    input  wire logic [CMD_W-1:0] command_select, // Operation code
    input  wire logic [DW-1:0] host_data_in,   // Data bus input
    output logic      [DW-1:0] host_data_out,  // Data bus output
    output logic               host_data_oe,   // High while driving the bus
    input  wire logic          fetch_req,      // Display fetch request
    input  wire logic [AW-1:0] fetch_addr,     // Display fetch address
    output logic      [DW-1:0] fetch_data,     // Fetched cursor byte
    output logic               fetch_valid,    // Fetched byte valid, pulse
    output logic               fetch_lost,     // Fetch displaced by host, pulse
    input  wire logic [DW-1:0] core_rd_data,   // Core register read data
    output logic               core_wr,        // Core register write, pulse
    output logic      [CMD_W-1:0] core_cmd,    // Command of the access
    output logic      [DW-1:0] core_wr_data,   // Byte written to the core
    output logic      [AW-1:0] pointer         // Address pointer
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] cs_sync;
    logic [SYNC_STAGES-1:0] rw_sync;
    logic [CMD_W-1:0]       cmd_s1, cmd_s2;
    logic [DW-1:0]          dat_s1, dat_s2;
    logic                   cs_q;
    logic                   next_cs_q;

    // all port logic runs on the core clock; strobe is sampled, not used as clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_sync <= '1;
            rw_sync <= '0;
            cmd_s1  <= CMD_RST;
            cmd_s2  <= CMD_RST;
            dat_s1  <= DATA_RST;
            dat_s2  <= DATA_RST;
        end else begin
            cs_sync <= {cs_sync[SYNC_STAGES-2:0], chip_sel_n};
            rw_sync <= {rw_sync[SYNC_STAGES-2:0], read_sel};
            cmd_s1  <= command_select;
            cmd_s2  <= cmd_s1;
            dat_s1  <= host_data_in;
            dat_s2  <= dat_s1;
        end
    end

    // Stage two and three agree before a level change counts
    always_comb begin
        next_cs_q = cs_q;
        if (cs_sync[1] == cs_sync[2]) begin
            next_cs_q = cs_sync[2];
        end
    end

    wire logic cs_fall = cs_q && !next_cs_q;
    wire logic cs_rise = !cs_q && next_cs_q;

    // ------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } pdh_state_t;

    pdh_state_t       state, next_state;
    logic [CMD_W-1:0] cmd_lat, next_cmd_lat;
    logic [DW-1:0]    next_data_out;
    logic             next_oe;
    logic             next_core_wr;
    logic [DW-1:0]    next_core_wr_data;
    logic [AW-1:0]    next_pointer;
    logic             mem_wr;
    logic [AW-1:0]    mem_addr;
    logic             host_mem;
    logic [DW-1:0]    mem_rd;
    logic             rd_pend, next_rd_pend;
    logic             fetch_pend, next_fetch_pend;
    logic             next_fetch_valid, next_fetch_lost;
    logic [DW-1:0]    next_fetch_data;

    function automatic logic is_cursor(input logic [CMD_W-1:0] c);
        return c == CMD_CURSOR;
    endfunction

    always_comb begin
        next_state        = state;
        next_cmd_lat      = cmd_lat;
        next_data_out     = host_data_out;
        next_oe           = host_data_oe;
        next_core_wr      = 1'b0;
        next_core_wr_data = core_wr_data;
        next_pointer      = pointer;
        next_rd_pend      = 1'b0;
        mem_wr            = 1'b0;
        host_mem          = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    next_cmd_lat = cmd_s2;
                    if (rw_sync[2]) begin
                        next_state   = ST_READ;
                        host_mem     = is_cursor(cmd_s2);
                        next_rd_pend = 1'b1;
                    end else begin
                        next_state = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (cs_rise) begin
                    next_state        = ST_IDLE;
                    next_core_wr_data = dat_s2;
                    if (is_cursor(cmd_lat)) begin
                        mem_wr       = 1'b1;
                        host_mem     = 1'b1;
                        next_pointer = pointer + 1'b1;
                    end else if (cmd_lat == CMD_POINTER) begin
                        next_pointer = {{(AW-DW){1'b0}}, dat_s2};
                    end else begin
                        next_core_wr = 1'b1;
                    end
                end
            end
            ST_READ: begin
                next_oe = 1'b1;
                if (rd_pend) begin
                    next_data_out = is_cursor(cmd_lat) ? mem_rd : core_rd_data;
                end
                if (cs_rise) begin
                    next_state = ST_IDLE;
                    next_oe    = 1'b0;
                    if (is_cursor(cmd_lat)) begin
                        next_pointer = pointer + 1'b1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Host wins the single memory port; a colliding fetch is reported lost
        mem_addr         = host_mem ? pointer : fetch_addr;
        next_fetch_pend  = fetch_req && !host_mem;
        next_fetch_lost  = fetch_req && host_mem;
        next_fetch_valid = fetch_pend;
        next_fetch_data  = fetch_pend ? mem_rd : fetch_data;
    end

    pdh_cursor_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clock   (clock),
        .wr_en   (mem_wr),
        .wr_addr (pointer),
        .wr_data (dat_s2),
        .rd_addr (mem_addr),
        .rd_data (mem_rd)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_q          <= 1'b1;
            state         <= ST_IDLE;
            cmd_lat       <= CMD_RST;
            host_data_out <= DATA_RST;
            host_data_oe  <= 1'b0;
            core_wr       <= 1'b0;
            core_wr_data  <= DATA_RST;
            pointer       <= PTR_RST;
            rd_pend       <= 1'b0;
            fetch_pend    <= 1'b0;
            fetch_valid   <= 1'b0;
            fetch_lost    <= 1'b0;
            fetch_data    <= DATA_RST;
        end else begin
            cs_q          <= next_cs_q;
            state         <= next_state;
            cmd_lat       <= next_cmd_lat;
            host_data_out <= next_data_out;
            host_data_oe  <= next_oe;
            core_wr       <= next_core_wr;
            core_wr_data  <= next_core_wr_data;
            pointer       <= next_pointer;
            rd_pend       <= next_rd_pend;
            fetch_pend    <= next_fetch_pend;
            fetch_valid   <= next_fetch_valid;
            fetch_lost    <= next_fetch_lost;
            fetch_data    <= next_fetch_data;
        end
    end

    assign core_cmd = cmd_lat;
endmodule
`default_nettype wire

//--- dv/pdh_checker.sv
// Purpose: Port timing checks for the host port
// Assumes: Host strobe low and high at least ten clocks each
// Notes:   Bound to every instance of the port
`timescale 1ns/1ns
`default_nettype none
module pdh_checker
    import pdh_pkg::*;
#(
    parameter int AW = CUR_ADDR_W
) (
    input wire logic               clock,          // Core clock
    input wire logic               rst,            // Reset
    input wire logic               chip_sel_n,     // Strobe
    input wire logic               read_sel,       // Direction
    input wire logic [DATA_W-1:0]  host_data_out,  // Bus drive value
    input wire logic               host_data_oe,   // Bus enable
    input wire logic               fetch_req,      // Fetch request
    input wire logic               fetch_valid,    // Fetch answer
    input wire logic               fetch_lost,     // Fetch dropped
    input wire logic               core_wr,        // Core write
    input wire logic [CMD_W-1:0]   core_cmd,       // Latched command
    input wire logic [AW-1:0]      pointer         // Address pointer
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_read_drives: assert property ($fell(chip_sel_n) && read_sel |-> ##[3:6] host_data_oe)
        else $error("bus not driven during read");
    a_drive_cause: assert property ($rose(host_data_oe) |-> !chip_sel_n && read_sel)
        else $error("bus driven outside a read");
    a_write_quiet: assert property ($fell(chip_sel_n) && !read_sel |-> ##6 !host_data_oe [*6])
        else $error("bus driven during write");
    a_drive_release: assert property ($rose(chip_sel_n) && host_data_oe |->
        host_data_oe [*3] ##[1:3] !host_data_oe)
        else $error("bus release out of time");
    a_read_steady: assert property ($rose(host_data_oe) |-> ##2 $stable(host_data_out) [*3])
        else $error("read data moved");
    a_write_on_rise: assert property (core_wr |->
        chip_sel_n && !$past(chip_sel_n, 7) && core_cmd inside {2'h1, 2'h2})
        else $error("core write out of place");
    a_pointer_moves: assert property ($changed(pointer) |-> chip_sel_n)
        else $error("pointer moved during strobe");
    a_fetch_answer: assert property (fetch_req |-> (##1 fetch_lost) or (##2 fetch_valid))
        else $error("fetch got no answer");
    // A dropped request must never yield a byte one cycle later; neighbours may still answer
    a_lost_cause: assert property (fetch_lost |-> $past(fetch_req) ##1 !fetch_valid)
        else $error("fetch lost without request");
    c_read: cover property ($rose(host_data_oe));
    c_write: cover property (core_wr);
    c_fetch: cover property (fetch_valid);
    c_lost: cover property (fetch_lost);
endmodule
bind pdh_host_port pdh_checker #(.AW(AW)) u_checker (.clock, .rst, .chip_sel_n, .read_sel,
    .host_data_out, .host_data_oe, .fetch_req, .fetch_valid, .fetch_lost, .core_wr, .core_cmd, .pointer);
`default_nettype wire

//--- dv/pdh_host_model.sv
// Purpose: Host processor side of the byte port
// Assumes: Strobe held ten clocks low, ten or more high
// Notes:   Undriven bus shows a changing pattern, it has no pull
`timescale 1ns/1ns
`default_nettype none
module pdh_host_model
    import pdh_pkg::*;
(
    input  wire logic               clock,          // Pacing clock
    output logic                    chip_sel_n,     // Strobe
    output logic                    read_sel,       // Direction
    output logic      [CMD_W-1:0]   command_select, // Operation
    output logic      [DATA_W-1:0]  host_data_in,   // Resolved bus
    input  wire logic [DATA_W-1:0]  host_data_out,  // Device drive value
    input  wire logic               host_data_oe    // Device drives
);
    logic              drive = 1'b0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [DATA_W-1:0] last = 8'h00;
    initial begin
        chip_sel_n = 1'b1;
        read_sel = 1'b0;
        command_select = 2'h0;
    end
    always_comb begin
        if (drive) host_data_in = wdata;
        else if (host_data_oe) host_data_in = host_data_out;
        else host_data_in = ~last;
    end
    always @(posedge clock) last <= host_data_in;
    task automatic access(input logic rd, input logic [CMD_W-1:0] cmd,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat);
        @(negedge clock);
        read_sel = rd;
        command_select = cmd;
        wdata = wd;
        drive = !rd;
        chip_sel_n = 1'b0;
        repeat (10) @(negedge clock);
        rdat = host_data_in;
        chip_sel_n = 1'b1;
        // Write data held past the rise so the device can latch it
        repeat (6) @(negedge clock);
        drive = 1'b0;
        repeat (6) @(negedge clock);
    endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the host port
// Assumes: Host model paces all strobe cycles
// Notes:   Random bytes from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pdh_pkg::*;
    logic clock, rst, fetch_req, core_wr, host_data_oe, fetch_valid, fetch_lost, chip_sel_n, read_sel;
    logic [CMD_W-1:0] command_select, core_cmd;
    logic [CUR_ADDR_W-1:0] fetch_addr, pointer;
    logic [DATA_W-1:0] core_rd_data, host_data_in, host_data_out, fetch_data, core_wr_data, rd, d, b;
    int bad_count = 0, total_checks = 0, seed = 85, wr_pulses = 0, lost_pulses = 0, n;
    pdh_host_port dut (.clock, .rst, .chip_sel_n, .read_sel, .command_select, .host_data_in, .host_data_out,
        .host_data_oe, .fetch_req, .fetch_addr, .fetch_data, .fetch_valid, .fetch_lost, .core_rd_data,
        .core_wr, .core_cmd, .core_wr_data, .pointer);
    pdh_host_model host (.clock, .chip_sel_n, .read_sel, .command_select, .host_data_in, .host_data_out,
        .host_data_oe);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) if (core_wr === 1'b1) wr_pulses++;
    always @(posedge clock) if (fetch_lost === 1'b1) lost_pulses++;
    function automatic logic [CUR_ADDR_W-1:0] ptr_after(input logic [7:0] v, input logic [1:0] k);
        return {2'h0, v} + k;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        fetch_req = 1'b0;
        fetch_addr = 10'h000;
        core_rd_data = 8'h00;
        repeat (3) @(negedge clock);
        check("pointer in reset", pointer, PTR_RST);
        rst = 1'b0;
        for (int c = 1; c < 3; c++) begin
            d = 8'($random(seed));
            n = wr_pulses;
            host.access(1'b0, c[1:0], d, rd);
            check("core write data", core_wr_data, d);
            check("core command", core_cmd, c[1:0]);
            check("core write count", wr_pulses, n + 1);
            core_rd_data = 8'($random(seed));
            host.access(1'b1, c[1:0], 8'h00, rd);
            check("core read data", rd, core_rd_data);
            check("write count after read", wr_pulses, n + 1);
        end
        for (int i = 0; i < 6; i++) begin
            b = (i == 0) ? 8'hff : 8'($random(seed));
            d = 8'($random(seed));
            host.access(1'b0, CMD_POINTER, b, rd);
            check("pointer load", pointer, ptr_after(b, 2'h0));
            // Display fetch kept busy so each host cursor access displaces exactly one request
            n = lost_pulses;
            fetch_req = 1'b1;
            host.access(1'b0, CMD_CURSOR, d, rd);
            check("pointer step", pointer, ptr_after(b, 2'h1));
            host.access(1'b0, CMD_POINTER, b, rd);
            host.access(1'b1, CMD_CURSOR, 8'h00, rd);
            fetch_req = 1'b0;
            check("cursor readback", rd, d);
            check("fetches lost to host", lost_pulses, n + 2);
            @(negedge clock);
            fetch_req = 1'b1;
            fetch_addr = ptr_after(b, 2'h0);
            @(negedge clock);
            fetch_req = 1'b0;
            @(negedge clock);
            check("fetch valid", fetch_valid, 1'b1);
            check("fetch data", fetch_data, d);
        end
        rst = 1'b1;
        @(negedge clock);
        check("pointer after reset", pointer, PTR_RST);
        check("bus idle", host_data_oe, 1'b0);
        rst = 1'b0;
        print_verdict();
    end
endmodule
`default_nettype wire
